// >>> core/crt_params.svh
// Purpose: Constants for the capture/reload timer
// Assumes: Included by bare name
// Notes: Register indices; byte address is four times the index
`ifndef CRT_PARAMS_SVH
`define CRT_PARAMS_SVH

`define CRT_IDX_CONTROL 8'hc8
`define CRT_IDX_MODE 8'hc9
`define CRT_IDX_RELOAD_LO 8'hca
`define CRT_IDX_RELOAD_HI 8'hcb
`define CRT_IDX_COUNT_LO 8'hcc
`define CRT_IDX_COUNT_HI 8'hcd
`define CRT_IDX_CLKCTL 8'hce

`define CRT_BIT_OVF 7
`define CRT_BIT_EXT 6
`define CRT_BIT_RCV 5
`define CRT_BIT_XMT 4
`define CRT_BIT_EXEN 3
`define CRT_BIT_RUN 2
`define CRT_BIT_CSEL 1
`define CRT_BIT_CPRL 0
`define CRT_BIT_TOE 1
`define CRT_BIT_DOWN_COUNT_ENABLE 0
`define CRT_BIT_PSC_APPLY 4
`define CRT_BIT_COMPAT 5
`define CRT_BIT_TIE 6

`define CRT_RST_CONTROL 8'h00
`define CRT_RST_MODE 8'h00
`define CRT_RST_CLKCTL 8'h00
`define CRT_RST_WORD 16'h0000
`define CRT_CNT_MIN 16'h0000
`define CRT_CNT_MAX 16'hffff

`endif

// >>> core/crt_pkg.sv
// Purpose: Types for the capture/reload timer
// Assumes: Nothing
// Notes: Mode follows the priority of the mode bits
package crt_pkg;
	typedef enum logic [2:0] {
		CRT_OFF,
		CRT_RELOAD,
		CRT_UPDOWN,
		CRT_CAPTURE,
		CRT_BAUD,
		CRT_FREQ
	} crt_mode_type;
endpackage

// >>> core/crt_timer.sv
// Purpose: 16-bit timer/counter with capture/reload register, AHB-Lite slave
// Assumes: Single word transfers, one master, hclk at 20 MHz
// Notes: Reads take one wait state; writes take none
// Operation
// - Overflow sets overflow flag bit 7; only software clears it.
// - No overflow flag set while either baud select is one.
// - Set overflow flag requests interrupt when interrupt enable is set.
// - Enabled trigger falling edge causing capture or reload sets external event flag.
// - External event flag raises no interrupt with down count enable.
// - Receive baud select routes overflow pulses to receive clock, else other timer.
// - Transmit baud select routes overflow pulses to transmit clock, else other timer.
// - Trigger edges act only when enabled; while clocking the serial port they only set external event flag.
// - Run control starts counting when one, stops when zero.
// - Counter select picks internal ticks or count pin falling edges.
// - Capture/reload select picks capture or reload; baud selects force reload.
// - Baud selects and toggle enable take priority over capture/reload select.
// - Toggle enable with timer function toggles count pin each overflow.
// - Down count enable with external enable makes direction follow trigger pin in auto-reload.
// - Down count enable resets to zero, counting up.
// - Capture mode counts freely minimum to maximum, flagging each wrap.
// - Capture copies count into reload bytes and sets external event flag.
// - Up auto-reload overflow sets flag and loads reload value.
// - Up auto-reload trigger edge forces reload and sets external event flag.
// - Down counting underflows at reload value loading maximum; up reloads floor.
// - Fast mode prescales only when applied; compatibility always, apply doubles; baud and clock-out modes never prescale.
// - Minimum 0000H, maximum FFFFH, floor is reload high and low bytes.
// - Count pin sampled each clock in fast mode, each prescale tick in compatibility; high then low counts one cycle later.
// - Down count enable with external enable toggles external event flag on each wrap in auto-reload.
`timescale 1ns/10ps
`include "crt_params.svh"

module crt_timer #(
	parameter int PSC_W = 4
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Pins
	input wire logic count_pin_in,
	output logic count_pin_out,
	output logic count_pin_oe_n,
	input wire logic trigger_pin_in,
	// Serial port clocks
	input wire logic other_timer_ovf,
	output logic rx_baud_tick,
	output logic tx_baud_tick,
	// Interrupt request
	output logic timer_irq
);
	// Prescale field is only four bits of clock control
	if (PSC_W < 1 || PSC_W > 4) begin : g_psc_bad
		$error("PSC_W out of range");
	end

	function automatic crt_pkg::crt_mode_type mode_of(input logic run, input logic baud,
		input logic toe, input logic cprl, input logic updn);
		if (!run)
			return crt_pkg::CRT_OFF;
		else if (baud)
			return crt_pkg::CRT_BAUD;
		else if (toe)
			return crt_pkg::CRT_FREQ;
		else if (cprl)
			return crt_pkg::CRT_CAPTURE;
		else if (updn)
			return crt_pkg::CRT_UPDOWN;
		else
			return crt_pkg::CRT_RELOAD;
	endfunction

	// Bus state
	logic wr_pend_ff;
	logic rd_wait_ff;
	logic addr_ok_ff;
	logic [7:0] idx_ff;
	logic [31:0] hrdata_ff;
	// Registers
	logic tf_ff;
	logic exf_ff;
	logic [5:0] ctl_ff;
	logic [1:0] mod_ff;
	logic [6:0] ckc_ff;
	logic [15:0] rld_ff;
	logic [15:0] cnt_ff;
	// Pins and prescaler
	logic cnt_s1_ff, cnt_s2_ff, cnt_prev_ff;
	logic trg_s1_ff, trg_s2_ff, trg_prev_ff;
	logic [PSC_W:0] psc_ff;
	logic tog_ff;

	logic ap_ok, wr_ctl, wr_mod, wr_rlo, wr_rhi, wr_clo, wr_chi, wr_ckc;
	logic [7:0] wdat;
	logic [7:0] rmux;
	logic baud, toe, csel, exen, run, cprl, down_count_enable, updn, capture;
	logic compat, psc_apply, tie;
	crt_pkg::crt_mode_type mode;
	logic [PSC_W:0] psc_top;
	logic psc_tick, samp_en, tick, pin_fall, trg_fall, inc;
	logic at_max, at_floor, ovf_evt, unf_evt, dn;
	logic [15:0] nxt_cnt;
	logic nxt_tf, nxt_exf, exf_base;

	// Address phase taken only while the bus is ready
	assign ap_ok = hsel & hready & htrans[1];
	assign hreadyout = ~rd_wait_ff;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;
	assign wdat = hwdata[7:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			rd_wait_ff <= 1'b0;
			addr_ok_ff <= 1'b0;
			idx_ff <= 8'h00;
		end else begin
			rd_wait_ff <= ap_ok & ~hwrite;
			if (hready) begin
				wr_pend_ff <= ap_ok & hwrite;
				addr_ok_ff <= (haddr[31:10] == 22'h00_0000) & (haddr[1:0] == 2'b00);
				idx_ff <= haddr[9:2];
			end
		end
	end

	assign wr_ctl = wr_pend_ff & addr_ok_ff & (idx_ff == `CRT_IDX_CONTROL);
	assign wr_mod = wr_pend_ff & addr_ok_ff & (idx_ff == `CRT_IDX_MODE);
	assign wr_rlo = wr_pend_ff & addr_ok_ff & (idx_ff == `CRT_IDX_RELOAD_LO);
	assign wr_rhi = wr_pend_ff & addr_ok_ff & (idx_ff == `CRT_IDX_RELOAD_HI);
	assign wr_clo = wr_pend_ff & addr_ok_ff & (idx_ff == `CRT_IDX_COUNT_LO);
	assign wr_chi = wr_pend_ff & addr_ok_ff & (idx_ff == `CRT_IDX_COUNT_HI);
	assign wr_ckc = wr_pend_ff & addr_ok_ff & (idx_ff == `CRT_IDX_CLKCTL);

	// Unmapped reads return zero
	always_comb begin
		rmux = 8'h00;
		if (addr_ok_ff) begin
			case (idx_ff)
				`CRT_IDX_CONTROL: rmux = {tf_ff, exf_ff, ctl_ff};
				`CRT_IDX_MODE: rmux = {6'h00, mod_ff};
				`CRT_IDX_RELOAD_LO: rmux = rld_ff[7:0];
				`CRT_IDX_RELOAD_HI: rmux = rld_ff[15:8];
				`CRT_IDX_COUNT_LO: rmux = cnt_ff[7:0];
				`CRT_IDX_COUNT_HI: rmux = cnt_ff[15:8];
				`CRT_IDX_CLKCTL: rmux = {1'b0, ckc_ff};
				default: rmux = 8'h00;
			endcase
		end
	end

	// Wait state lets a read see the effect of a write just before it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata_ff <= 32'h0000_0000;
		else if (rd_wait_ff)
			hrdata_ff <= {24'h00_0000, rmux};
	end

	// Control fields
	assign baud = ctl_ff[`CRT_BIT_RCV] | ctl_ff[`CRT_BIT_XMT];
	assign exen = ctl_ff[`CRT_BIT_EXEN];
	assign run = ctl_ff[`CRT_BIT_RUN];
	assign csel = ctl_ff[`CRT_BIT_CSEL];
	assign cprl = ctl_ff[`CRT_BIT_CPRL];
	assign toe = mod_ff[`CRT_BIT_TOE];
	assign down_count_enable = mod_ff[`CRT_BIT_DOWN_COUNT_ENABLE];
	assign psc_apply = ckc_ff[`CRT_BIT_PSC_APPLY];
	assign compat = ckc_ff[`CRT_BIT_COMPAT];
	assign tie = ckc_ff[`CRT_BIT_TIE];
	assign updn = down_count_enable & exen;
	assign mode = mode_of(run, baud, toe, cprl, updn);
	assign capture = (mode == crt_pkg::CRT_CAPTURE);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_ff <= 6'(`CRT_RST_CONTROL);
			mod_ff <= 2'(`CRT_RST_MODE);
			ckc_ff <= 7'(`CRT_RST_CLKCTL);
		end else begin
			if (wr_ctl)
				ctl_ff <= wdat[5:0];
			if (wr_mod)
				mod_ff <= wdat[1:0];
			if (wr_ckc)
				ckc_ff <= wdat[6:0];
		end
	end

	// Prescaler: apply doubles the divide in compatibility mode
	assign psc_top = compat ? (psc_apply ? {ckc_ff[PSC_W-1:0], 1'b1} : {1'b0, ckc_ff[PSC_W-1:0]})
		: {1'b0, ckc_ff[PSC_W-1:0]};
	// Top lowered mid-count must not stall the divider for a full wrap
	assign psc_tick = (psc_ff >= psc_top);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			psc_ff <= '0;
		else if (psc_tick)
			psc_ff <= '0;
		else
			psc_ff <= psc_ff + 1'b1;
	end

	// Baud and clock-out run unprescaled
	assign tick = (mode == crt_pkg::CRT_BAUD) | (mode == crt_pkg::CRT_FREQ) | (!compat & !psc_apply)
		| psc_tick;
	assign samp_en = compat ? psc_tick : 1'b1;

	// Pin synchronisers and edge detect
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_s1_ff <= 1'b1;
			cnt_s2_ff <= 1'b1;
			cnt_prev_ff <= 1'b1;
			trg_s1_ff <= 1'b1;
			trg_s2_ff <= 1'b1;
			trg_prev_ff <= 1'b1;
		end else begin
			cnt_s1_ff <= count_pin_in;
			cnt_s2_ff <= cnt_s1_ff;
			trg_s1_ff <= trigger_pin_in;
			trg_s2_ff <= trg_s1_ff;
			trg_prev_ff <= trg_s2_ff;
			if (samp_en)
				cnt_prev_ff <= cnt_s2_ff;
		end
	end

	assign pin_fall = samp_en & cnt_prev_ff & ~cnt_s2_ff;
	assign trg_fall = exen & trg_prev_ff & ~trg_s2_ff;
	assign inc = run & (csel ? pin_fall : tick);
	assign dn = (mode == crt_pkg::CRT_UPDOWN) & ~trg_s2_ff;
	assign at_max = (cnt_ff == `CRT_CNT_MAX);
	assign at_floor = (cnt_ff == rld_ff);
	assign ovf_evt = inc & ~dn & at_max;
	assign unf_evt = inc & dn & at_floor;

	// Count next value; software write wins over hardware
	always_comb begin
		nxt_cnt = cnt_ff;
		if (inc) begin
			if (dn)
				nxt_cnt = at_floor ? `CRT_CNT_MAX : cnt_ff - 16'h0001;
			else if (at_max)
				nxt_cnt = capture ? `CRT_CNT_MIN : rld_ff;
			else
				nxt_cnt = cnt_ff + 16'h0001;
		end
		if (trg_fall & run & ~baud & ~capture & (mode != crt_pkg::CRT_UPDOWN))
			nxt_cnt = rld_ff;
		if (wr_clo)
			nxt_cnt = {nxt_cnt[15:8], wdat};
		if (wr_chi)
			nxt_cnt = {wdat, nxt_cnt[7:0]};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cnt_ff <= `CRT_RST_WORD;
		else
			cnt_ff <= nxt_cnt;
	end

	// Capture beats a software write in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rld_ff <= `CRT_RST_WORD;
		else if (trg_fall & capture)
			rld_ff <= cnt_ff;
		else begin
			if (wr_rlo)
				rld_ff[7:0] <= wdat;
			if (wr_rhi)
				rld_ff[15:8] <= wdat;
		end
	end

	// Flags: hardware set wins over software clear
	always_comb begin
		nxt_tf = wr_ctl ? wdat[`CRT_BIT_OVF] : tf_ff;
		if ((ovf_evt | unf_evt) & ~baud)
			nxt_tf = 1'b1;
		exf_base = wr_ctl ? wdat[`CRT_BIT_EXT] : exf_ff;
		nxt_exf = exf_base;
		if (mode == crt_pkg::CRT_UPDOWN) begin
			if (ovf_evt | unf_evt)
				nxt_exf = ~exf_base;
		end else if (trg_fall)
			nxt_exf = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tf_ff <= 1'b0;
			exf_ff <= 1'b0;
		end else begin
			tf_ff <= nxt_tf;
			exf_ff <= nxt_exf;
		end
	end

	assign timer_irq = tie & (tf_ff | (exf_ff & ~down_count_enable));

	// Clock-out pin toggles on overflow
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			tog_ff <= 1'b0;
		else if (ovf_evt & toe & ~csel)
			tog_ff <= ~tog_ff;
	end

	assign count_pin_out = tog_ff;
	assign count_pin_oe_n = ~(toe & ~csel);

	// Serial clock source; the UART picks modes 1 and 3
	assign rx_baud_tick = ctl_ff[`CRT_BIT_RCV] ? ovf_evt : other_timer_ovf;
	assign tx_baud_tick = ctl_ff[`CRT_BIT_XMT] ? ovf_evt : other_timer_ovf;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_TF_SET: assert property (ovf_evt & ~baud |=> tf_ff) else $error("overflow flag not set");
	AST_TF_BAUD: assert property (baud & ~tf_ff & ~wr_ctl |=> ~tf_ff) else $error("flag set in baud mode");
	AST_IRQ: assert property (tf_ff & tie |-> timer_irq) else $error("interrupt missing");
	AST_EXF_TRIG: assert property (trg_fall & (mode != crt_pkg::CRT_UPDOWN) |=> exf_ff)
		else $error("event flag not set");
	AST_EXF_NOIRQ: assert property (down_count_enable & ~tf_ff |-> ~timer_irq) else $error("event flag interrupted");
	AST_RUN: assert property (~run & ~wr_clo & ~wr_chi & ~trg_fall |=> $stable(cnt_ff))
		else $error("count moved while stopped");
	AST_CAP: assert property (trg_fall & capture |=> rld_ff == $past(cnt_ff)) else $error("capture wrong");
	AST_RELOAD: assert property (ovf_evt & (mode == crt_pkg::CRT_RELOAD) & ~wr_clo & ~wr_chi
		|=> cnt_ff == $past(rld_ff)) else $error("reload wrong");
	AST_DOWN: assert property (unf_evt & ~wr_clo & ~wr_chi |=> cnt_ff == `CRT_CNT_MAX)
		else $error("underflow load wrong");
	AST_TOGGLE: assert property (ovf_evt & toe & ~csel |=> count_pin_out != $past(count_pin_out))
		else $error("pin not toggled");
	AST_READ_WAIT: assert property (ap_ok & ~hwrite |=> ~hreadyout ##1 hreadyout)
		else $error("read wait wrong");

	COV_CAPTURE: cover property (trg_fall & capture);
	COV_RELOAD: cover property (ovf_evt & (mode == crt_pkg::CRT_RELOAD));
	COV_UNDERFLOW: cover property (unf_evt);
	COV_IRQ: cover property (~timer_irq ##1 timer_irq);
endmodule

// >>> verification/crt_pin_model.sv
// Purpose: Far-side model of the count and trigger pins
// Assumes: Tasks called just after a rising clock edge
// Notes: Both pins idle high, as if pulled up
`timescale 1ns/10ps

module crt_pin_model (
	// Clock
	input wire logic hclk,
	// Pin driven by the timer
	input wire logic count_pin_out,
	input wire logic count_pin_oe_n,
	// Pin levels seen by the timer
	output logic count_pin_in,
	output logic trigger_pin_in
);
	logic drv_ff = 1'b1;

	initial trigger_pin_in = 1'b1;
	// Shared pin: timer wins while it drives
	assign count_pin_in = count_pin_oe_n ? drv_ff : count_pin_out;

	// Levels held 3 cycles, well past the one-clock minimum
	task pulse_count(input int n);
		repeat (n) begin
			drv_ff <= 1'b0;
			repeat (3) @(posedge hclk);
			drv_ff <= 1'b1;
			repeat (3) @(posedge hclk);
		end
	endtask

	task fall_trigger;
		trigger_pin_in <= 1'b0;
		repeat (6) @(posedge hclk);
		trigger_pin_in <= 1'b1;
		repeat (6) @(posedge hclk);
	endtask

	task set_trigger(input logic v);
		trigger_pin_in <= v;
		repeat (4) @(posedge hclk);
	endtask
endmodule

// >>> verification/crt_timer_tb.sv
// Purpose: Self-checking bench for the capture/reload timer
// Assumes: One AHB-Lite master, fast mode except in the prescale rate checks
// Notes: Prescale rates checked last; baud ticks are pulses
`timescale 1ns/10ps
`include "crt_params.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s exp %h got %h", nm, e, g); end end

module crt_timer_tb;
	localparam logic [7:0] I_CT = `CRT_IDX_CONTROL;
	localparam logic [7:0] I_MD = `CRT_IDX_MODE;
	localparam logic [7:0] I_RL = `CRT_IDX_RELOAD_LO;
	localparam logic [7:0] I_RH = `CRT_IDX_RELOAD_HI;
	localparam logic [7:0] I_CL = `CRT_IDX_COUNT_LO;
	localparam logic [7:0] I_CH = `CRT_IDX_COUNT_HI;
	localparam logic [7:0] I_CK = `CRT_IDX_CLKCTL;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ovf_in = 1'b0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [7:0] rd;
	logic txs;
	wire hreadyout, hresp, cpo, cpoe_n, cpi, tpi, rxt, txt, irq;
	wire [31:0] hrdata;
	int failures = 0, n_compared = 0;

	initial forever #25 hclk = ~hclk;

	crt_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .count_pin_in(cpi), .count_pin_out(cpo),
		.count_pin_oe_n(cpoe_n), .trigger_pin_in(tpi), .other_timer_ovf(ovf_in),
		.rx_baud_tick(rxt), .tx_baud_tick(txt), .timer_irq(irq));
	crt_pin_model PM (.hclk(hclk), .count_pin_out(cpo), .count_pin_oe_n(cpoe_n),
		.count_pin_in(cpi), .trigger_pin_in(tpi));

	task test_done;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Ready sampled mid-cycle, so the edge never races the slave
	task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] d);
		int n;
		logic r;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {22'h0, idx, 2'h0};
		do begin @(negedge hclk); r = hreadyout; @(posedge hclk); n++; end while (r !== 1'b1 && n < 20);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do begin
			@(negedge hclk);
			r = hreadyout;
			d = hrdata[7:0];
			@(posedge hclk);
			n++;
		end while (r !== 1'b1 && n < 40);
		if (n >= 40) begin failures++; test_done(); end
	endtask

	task wr(input logic [7:0] idx, input logic [7:0] v);
		bus(1'b1, idx, v, rd);
	endtask

	task ck(input logic [7:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00, rd);
		`CHK($sformatf("reg %h", idx), e, rd)
	endtask

	// Wait for irq (0), receive tick (1) or pin-out high (2)
	task wt(input int s);
		int n;
		logic v;
		n = 0;
		v = 1'b0;
		while (v !== 1'b1 && n < 400) begin
			@(negedge hclk);
			v = (s == 0) ? irq : (s == 1) ? rxt : cpo;
			txs = txt;
			n++;
		end
		@(posedge hclk);
		if (n >= 400) begin failures++; test_done(); end
	endtask

	task ckirq(input logic e);
		@(negedge hclk);
		`CHK("irq", e, irq)
		@(posedge hclk);
	endtask

	// Count over 20 edges; a span that is a multiple of four makes the result independent of divider phase
	task rate(input logic [7:0] c, input logic [7:0] e);
		wr(I_CK, c);
		wr(I_CL, 8'h00);
		wr(I_CH, 8'h00);
		wr(I_CT, 8'h04);
		repeat (18) @(posedge hclk);
		wr(I_CT, 8'h00);
		ck(I_CL, e);
	endtask

	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ck(I_CT, 8'h00);
		ck(I_MD, 8'h00);
		ck(I_CK, 8'h00);
		ck(8'hff, 8'h00);
		wr(I_RL, 8'h34); wr(I_RH, 8'h12); wr(I_CL, 8'hfe); wr(I_CH, 8'hff);
		wr(I_CK, 8'h40);
		wr(I_CT, 8'h04);
		wt(0);
		wr(I_CT, 8'h80);
		ck(I_CH, 8'h12);
		ck(I_CT, 8'h80);
		ckirq(1'b1);
		wr(I_CT, 8'h00);
		ckirq(1'b0);
		wr(I_CL, 8'h00); wr(I_CH, 8'h05); wr(I_CT, 8'h0d);
		PM.fall_trigger();
		ck(I_CT, 8'h4d);
		wr(I_CT, 8'h00);
		ck(I_RH, 8'h05);
		wr(I_CT, 8'h05);
		PM.fall_trigger();
		ck(I_CT, 8'h05);
		wr(I_CT, 8'h00);
		// Capture mode wraps to minimum; count loaded while stopped
		wr(I_CL, 8'hfe);
		wr(I_CH, 8'hff);
		wr(I_CT, 8'h05);
		wt(0);
		ck(I_CH, 8'h00);
		ck(I_CT, 8'h85);
		wr(I_CT, 8'h00);
		wr(I_CL, 8'hfd); wr(I_CH, 8'hff); wr(I_CT, 8'h34);
		wt(1);
		`CHK("tx tick", 1'b1, txs)
		ck(I_CT, 8'h34);
		wr(I_CT, 8'h00);
		ovf_in <= 1'b1;
		@(negedge hclk);
		`CHK("rx other", 1'b1, rxt)
		`CHK("tx other", 1'b1, txt)
		@(posedge hclk);
		ovf_in <= 1'b0;
		wr(I_CL, 8'h00); wr(I_CH, 8'h00); wr(I_CT, 8'h06);
		PM.pulse_count(3);
		ck(I_CL, 8'h03);
		wr(I_CT, 8'h00);
		wr(I_RL, 8'hf0); wr(I_RH, 8'hff); wr(I_MD, 8'h02);
		wr(I_CL, 8'hf0);
		wr(I_CH, 8'hff);
		wr(I_CT, 8'h04);
		wt(2);
		@(negedge hclk);
		`CHK("pin oe_n", 1'b0, cpoe_n)
		@(posedge hclk);
		wr(I_CT, 8'h00); wr(I_MD, 8'h00);
		// Down count from just above the floor to force an underflow
		wr(I_RL, 8'h10); wr(I_RH, 8'h00); wr(I_CL, 8'h14); wr(I_CH, 8'h00); wr(I_MD, 8'h01);
		PM.set_trigger(1'b0);
		wr(I_CT, 8'h0c);
		wt(0);
		ck(I_CT, 8'hcc);
		wr(I_CT, 8'h48);
		ck(I_CH, 8'hff);
		ckirq(1'b0);
		wr(I_CT, 8'h00); wr(I_MD, 8'h00);
		PM.set_trigger(1'b1);
		rate(8'h41, 8'h14);
		rate(8'h51, 8'h0a);
		rate(8'h61, 8'h0a);
		rate(8'h71, 8'h05);
		test_done();
	end
endmodule
